// ===== include/ret_consts.svh
`ifndef RET_CONSTS_SVH
`define RET_CONSTS_SVH
// register byte offsets
`define RET_OFS_CTRL      8'h00
`define RET_OFS_SRC       8'h04
`define RET_OFS_DIV       8'h08
`define RET_OFS_SKIP      8'h0C
`define RET_OFS_FILT      8'h10
`define RET_OFS_STRB      8'h14
`define RET_OFS_MAXI      8'h18
`define RET_OFS_BACKLOG   8'h1C
`define RET_OFS_STATUS    8'h20
// control field positions
`define RET_CTRL_METHOD   0
`define RET_CTRL_POL_LSB  4
`define RET_CTRL_AVG_LSB  8
`define RET_CTRL_SENSE    12
`define RET_CTRL_BEGIN    16
`define RET_CTRL_STOP     17
`define RET_SRC_B_LSB     8
// encodings
`define RET_POL_FWD       3'h1
`define RET_POL_REV       3'h2
`define RET_POL_MOTION    3'h5
`define RET_LINE_TTL1     6'h17
`define RET_LINE_OPT1     6'h18
`define RET_LINE_TTL4     6'h21
// reset values
`define RET_RST_DIV       32'h0001_0000
`define RET_RST_SKIP      16'h0000
`define RET_RST_FILT_NS   8'h00
`define RET_RST_STRB_NS   12'h064
`define RET_RST_MAXI_S    6'h00
// timing
`define RET_CLK_NS        100
`define RET_RATIO_ONE     65536
`define RET_CYC_PER_S     (1000000000 / `RET_CLK_NS)
`endif

// ===== include/ret_pkg.sv
package ret_pkg;
  typedef enum logic {RET_RATIO, RET_SKIP} ret_method_e;
  typedef enum logic [1:0] {RET_FWD, RET_REV, RET_MOTION} ret_policy_e;
  typedef logic [29:0] ret_period_t;
endpackage

// ===== design/ret_line_trigger.sv
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "ret_consts.svh"
// What this block does
// - ratio mode: 65536/divisor triggers per pulse
// - edge-skip mode passes programmed edges between triggers
// - policy codes 1 forward, 2 reverse, 5 motion
// - forward policy, once capture begins: images at new forward positions and at any reverse step made at zero backlog
// - reverse policy, once capture begins: images at new reverse positions and at any forward step made at zero backlog
// - after reversal suppress images until backlog zero
// - backlog counts reverse pulses after capture begins
// - backlog decrements on return to policy direction
// - inputs glitch filtered, 0-150 ns stability
// - trigger pulse width 10-2550 ns, default 100
// - interval smoothing over 2..32 pulses, code 0 off
// - smoothing only in non-integer ratio mode
// - max interval zero: period from input only
// - max interval 1-60 s caps measured input period
// - max interval ignored for integer-multiple divisors
// - method code 0 ratio, 1 edge skip
// - each phase from selectable line, default off
module ret_line_trigger
  import ret_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic [2:0]  line_in,
  output logic             trigger_out,
  output logic             image_trigger_out,
  output logic             image_enable_out
);

  //////////////////////////////////////////////////////////////////////////////
  logic        method_reg;
  logic [2:0]  policy_reg;
  logic [2:0]  avg_reg;
  logic        sense_reg;
  logic        active_reg;
  logic [5:0]  src_a_reg;
  logic [5:0]  src_b_reg;
  logic [31:0] div_reg;
  logic [15:0] skip_reg;
  logic [7:0]  filt_reg;
  logic [11:0] strb_reg;
  logic [5:0]  maxi_reg;
  logic [31:0] backlog_reg;
  logic        dir_reg;
  logic        wr_ctrl;
  logic        avg_clr;

  assign wr_ctrl = reg_wr && reg_addr == `RET_OFS_CTRL;
  assign avg_clr = wr_ctrl && reg_wdata[`RET_CTRL_AVG_LSB +: 3] != avg_reg;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      method_reg <= 1'b0;
      policy_reg <= `RET_POL_MOTION;
      avg_reg    <= 3'h0;
      sense_reg  <= 1'b0;
      src_a_reg  <= 6'h00;
      src_b_reg  <= 6'h00;
      div_reg    <= `RET_RST_DIV;
      skip_reg   <= `RET_RST_SKIP;
      filt_reg   <= `RET_RST_FILT_NS;
      strb_reg   <= `RET_RST_STRB_NS;
      maxi_reg   <= `RET_RST_MAXI_S;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        `RET_OFS_CTRL:
        begin
          method_reg <= reg_wdata[`RET_CTRL_METHOD];
          policy_reg <= reg_wdata[`RET_CTRL_POL_LSB +: 3];
          avg_reg    <= reg_wdata[`RET_CTRL_AVG_LSB +: 3];
          sense_reg  <= reg_wdata[`RET_CTRL_SENSE];
        end
        `RET_OFS_SRC:
        begin
          src_a_reg <= reg_wdata[5:0];
          src_b_reg <= reg_wdata[`RET_SRC_B_LSB +: 6];
        end
        // a divisor of zero is out of range; hold it at one
        `RET_OFS_DIV:  div_reg  <= (reg_wdata == 32'h0) ? 32'h1 : reg_wdata;
        `RET_OFS_SKIP: skip_reg <= reg_wdata[15:0];
        `RET_OFS_FILT: filt_reg <= reg_wdata[7:0];
        `RET_OFS_STRB: strb_reg <= reg_wdata[11:0];
        `RET_OFS_MAXI: maxi_reg <= reg_wdata[5:0];
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // input sync, line select and glitch filter per phase
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [1:0] phase_raw;
  logic [1:0] phase_filt_reg;
  logic [1:0] filt_cyc;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end
    else
    begin
      sync1_reg <= line_in;
      sync2_reg <= sync1_reg;
    end
  end

  function automatic logic pick_line(input logic [5:0] sel, input logic [2:0] lines);
    logic v;
    v = 1'b0;
    if (sel == `RET_LINE_TTL1) v = lines[0];
    else if (sel == `RET_LINE_OPT1) v = lines[1];
    else if (sel == `RET_LINE_TTL4) v = lines[2];
    return v;
  endfunction

  assign phase_raw[0] = pick_line(src_a_reg, sync2_reg);
  assign phase_raw[1] = pick_line(src_b_reg, sync2_reg);
  // stability time rounds up to whole clocks, so 10..100 ns is one clock
  assign filt_cyc = 2'((16'(filt_reg) + 16'(`RET_CLK_NS - 1)) / 16'(`RET_CLK_NS));

  for (genvar g = 0; g < 2; g++)
  begin : g_filt
    logic [1:0] cnt_reg;
    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
      begin
        cnt_reg           <= 2'h0;
        phase_filt_reg[g] <= 1'b0;
      end
      else if (phase_raw[g] == phase_filt_reg[g])
        cnt_reg <= 2'h0;
      else if (cnt_reg + 2'h1 >= filt_cyc)
      begin
        cnt_reg           <= 2'h0;
        phase_filt_reg[g] <= phase_raw[g];
      end
      else
        cnt_reg <= cnt_reg + 2'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // quadrature decode
  logic [1:0] qprev_reg;
  logic       step;
  logic       step_dir;
  logic       pos_dir;
  logic       want_dir;
  ret_policy_e policy;

  assign step     = ^(qprev_reg ^ phase_filt_reg);
  assign step_dir = qprev_reg[0] ^ phase_filt_reg[1];
  assign pos_dir  = step_dir ^ sense_reg;
  assign policy   = (policy_reg == `RET_POL_FWD) ? RET_FWD :
                    (policy_reg == `RET_POL_REV) ? RET_REV : RET_MOTION;
  assign want_dir = (policy == RET_FWD) ? pos_dir : !pos_dir;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      qprev_reg <= 2'h0;
      dir_reg   <= 1'b0;
    end
    else
    begin
      qprev_reg <= phase_filt_reg;
      if (step)
        dir_reg <= pos_dir;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // backlog of reverse pulses, counted only after capture begins
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      active_reg  <= 1'b0;
      backlog_reg <= 32'h0;
    end
    else if (wr_ctrl && reg_wdata[`RET_CTRL_BEGIN])
    begin
      active_reg  <= 1'b1;
      backlog_reg <= 32'h0;
    end
    else
    begin
      if (wr_ctrl && reg_wdata[`RET_CTRL_STOP])
        active_reg <= 1'b0;
      if (step && active_reg && policy != RET_MOTION)
      begin
        if (!want_dir && backlog_reg != 32'hFFFF_FFFF)
          backlog_reg <= backlog_reg + 32'h1;
        else if (want_dir && backlog_reg != 32'h0)
          backlog_reg <= backlog_reg - 32'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // input period measurement and optional moving average
  ret_period_t run_reg;
  ret_period_t per_reg;
  ret_period_t ring [32];
  logic [4:0]  wp_reg;
  logic [5:0]  fill_reg;
  logic [34:0] sum_reg;
  logic [5:0]  avg_n;
  ret_period_t avg_per;
  logic        int_ratio;

  assign int_ratio = div_reg[15:0] == 16'h0;
  assign avg_n     = 6'h1 << avg_reg;
  assign avg_per   = 30'(sum_reg >> avg_reg);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      run_reg <= '0;
      per_reg <= '0;
    end
    else if (step)
    begin
      per_reg <= run_reg;
      // restart at one so the stored count is the whole period in clocks
      run_reg <= 30'h1;
    end
    else if (run_reg != '1)
      run_reg <= run_reg + 30'h1;
  end

  // the ring is never cleared: entries older than the fill count are never read
  always_ff @(posedge clk)
  begin
    if (step)
      ring[wp_reg] <= run_reg;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wp_reg   <= 5'h0;
      fill_reg <= 6'h0;
      sum_reg  <= '0;
    end
    else if (avg_clr)
    begin
      fill_reg <= 6'h0;
      sum_reg  <= '0;
    end
    else if (step)
    begin
      wp_reg  <= wp_reg + 5'h1;
      if (fill_reg < avg_n)
      begin
        fill_reg <= fill_reg + 6'h1;
        sum_reg  <= sum_reg + 35'(run_reg);
      end
      else
        sum_reg <= sum_reg + 35'(run_reg) - 35'(ring[5'(wp_reg - 5'(avg_n))]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // trigger generation
  ret_period_t per_eff;
  ret_period_t cap;
  logic [61:0] thr_reg;
  logic [62:0] acc_reg;
  logic [62:0] acc_sum;
  logic [15:0] k_cnt_reg;
  logic [15:0] e_cnt_reg;
  logic        fire;
  ret_method_e method;

  assign method  = ret_method_e'(method_reg);
  assign cap     = 30'(32'(maxi_reg) * 32'(`RET_CYC_PER_S));
  assign acc_sum = acc_reg + 63'(`RET_RATIO_ONE);

  always_comb
  begin
    per_eff = per_reg;
    if (avg_reg != 3'h0 && fill_reg >= avg_n)
      per_eff = avg_per;
    if (maxi_reg != 6'h0 && per_eff > cap)
      per_eff = cap;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      thr_reg <= '0;
    else
      thr_reg <= 62'(per_eff) * 62'(div_reg);
  end

  always_comb
  begin
    fire = 1'b0;
    if (method == RET_SKIP)
      fire = step && e_cnt_reg == skip_reg;
    else if (int_ratio)
      fire = step && k_cnt_reg == 16'(div_reg[31:16] - 16'h1);
    else
      fire = run_reg != '1 && thr_reg != '0 && acc_sum >= 63'(thr_reg);
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      k_cnt_reg <= 16'h0;
      e_cnt_reg <= 16'h0;
      acc_reg   <= '0;
    end
    else
    begin
      if (step)
      begin
        e_cnt_reg <= (e_cnt_reg == skip_reg) ? 16'h0 : e_cnt_reg + 16'h1;
        k_cnt_reg <= (k_cnt_reg >= 16'(div_reg[31:16] - 16'h1)) ? 16'h0 : k_cnt_reg + 16'h1;
      end
      // pacing stops once the encoder has stalled long enough to saturate
      if (run_reg == '1 || int_ratio || method == RET_SKIP)
        acc_reg <= '0;
      else if (fire)
        acc_reg <= acc_sum - 63'(thr_reg);
      else
        acc_reg <= acc_sum;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // strobe width and image gating
  logic [4:0] strb_cyc;
  logic [4:0] hold_reg;
  logic       img_ok;

  assign strb_cyc = (strb_reg < 12'(`RET_CLK_NS)) ? 5'h1 :
                    5'((strb_reg + 12'(`RET_CLK_NS - 1)) / 12'(`RET_CLK_NS));
  assign img_ok   = policy == RET_MOTION || backlog_reg == 32'h0;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      hold_reg          <= 5'h0;
      trigger_out       <= 1'b0;
      image_trigger_out <= 1'b0;
      image_enable_out  <= 1'b1;
    end
    else
    begin
      // a new trigger restarts the strobe rather than being dropped
      if (fire)
        hold_reg <= strb_cyc - 5'h1;
      else if (hold_reg != 5'h0)
        hold_reg <= hold_reg - 5'h1;
      trigger_out       <= fire || hold_reg != 5'h0;
      image_enable_out  <= img_ok;
      if (fire)
        image_trigger_out <= img_ok;
      else if (hold_reg == 5'h0)
        image_trigger_out <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= 32'h0;
    else if (!reg_rd)
      reg_rdata <= 32'h0;
    else
    begin
      unique case (reg_addr)
        `RET_OFS_CTRL:    reg_rdata <= {19'h0, sense_reg, 1'b0, avg_reg, 1'b0, policy_reg, 3'h0, method_reg};
        `RET_OFS_SRC:     reg_rdata <= {18'h0, src_b_reg, 2'h0, src_a_reg};
        `RET_OFS_DIV:     reg_rdata <= div_reg;
        `RET_OFS_SKIP:    reg_rdata <= {16'h0, skip_reg};
        `RET_OFS_FILT:    reg_rdata <= {24'h0, filt_reg};
        `RET_OFS_STRB:    reg_rdata <= {20'h0, strb_reg};
        `RET_OFS_MAXI:    reg_rdata <= {26'h0, maxi_reg};
        `RET_OFS_BACKLOG: reg_rdata <= backlog_reg;
        `RET_OFS_STATUS:  reg_rdata <= {28'h0, img_ok, active_reg, phase_filt_reg == qprev_reg, dir_reg};
        default:          reg_rdata <= 32'h0;
      endcase
    end
  end

endmodule

// ===== tb/ret_encoder_model.sv
`timescale 1ns/1ps
// quadrature encoder on lines 0 and 1; line 2 toggles so an unselected line is never quiet
module ret_encoder_model (
  input  wire logic       clk,
  input  wire logic       step,
  input  wire logic       fwd,
  output logic      [2:0] line_out
);
  logic [1:0] pos_reg = 2'h0;
  logic       noise_reg = 1'b0;
  ////////////////////////////////////////
  always @(posedge clk)
  begin
    noise_reg <= !noise_reg;
    if (step)
      pos_reg <= fwd ? pos_reg + 2'h1 : pos_reg - 2'h1;
  end
  // gray order: a forward step gives old A xor new B = 1
  assign line_out = {noise_reg, pos_reg[1] ^ pos_reg[0], pos_reg[1]};
endmodule

// ===== tb/ret_line_trigger_monitor.sv
`timescale 1ns/1ps
`include "ret_consts.svh"
module ret_line_trigger_monitor (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [2:0]  line_in,
  input wire logic        trigger_out,
  input wire logic        image_trigger_out,
  input wire logic        image_enable_out
);
  logic [31:0] div_reg;
  logic [15:0] skip_reg;
  logic [4:0]  strb_reg;
  logic        meth_reg;
  logic        mot_reg;
  logic        src_reg;
  logic [7:0]  run_reg;
  logic [4:0]  quiet_reg;
  logic [1:0]  ln_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  // shadow of the settings the assertions depend on
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      div_reg  <= `RET_RST_DIV;
      skip_reg <= `RET_RST_SKIP;
      strb_reg <= 5'h01;
      meth_reg <= 1'b0;
      mot_reg  <= 1'b1;
      src_reg  <= 1'b0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `RET_OFS_DIV:  div_reg <= (reg_wdata == 32'h0) ? 32'h1 : reg_wdata;
        `RET_OFS_SKIP: skip_reg <= reg_wdata[15:0];
        `RET_OFS_STRB: strb_reg <= 5'((reg_wdata[11:0] + 12'h063) / 12'h064);
        `RET_OFS_SRC:  src_reg <= src_reg || (reg_wdata[13:0] != 14'h0);
        `RET_OFS_CTRL:
        begin
          meth_reg <= reg_wdata[0];
          mot_reg  <= !(reg_wdata[6:4] inside {`RET_POL_FWD, `RET_POL_REV});
        end
        default: ;
      endcase
    end
  end
  // a source write may create a phase edge by re-routing a line, so any write restarts the quiet count
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      run_reg   <= 8'h00;
      quiet_reg <= 5'h00;
      ln_reg    <= 2'h0;
    end
    else
    begin
      ln_reg    <= line_in[1:0];
      run_reg   <= trigger_out ? run_reg + 8'(run_reg != 8'hFF) : 8'h00;
      quiet_reg <= (reg_wr || line_in[1:0] != ln_reg) ? 5'h00 : quiet_reg + 5'(quiet_reg != 5'h1F);
    end
  end
  ////////////////////////////////////////
  property p_div_rb;
    reg_rd && reg_addr == `RET_OFS_DIV |=> reg_rdata == div_reg;
  endproperty
  a_div_rb: assert property (p_div_rb) else $error("divisor readback wrong");
  property p_skip_rb;
    reg_rd && reg_addr == `RET_OFS_SKIP |=> reg_rdata == {16'h0000, skip_reg};
  endproperty
  a_skip_rb: assert property (p_skip_rb) else $error("skip count readback wrong");
  property p_mot_en;
    mot_reg [*2] |-> image_enable_out;
  endproperty
  a_mot_en: assert property (p_mot_en) else $error("images blocked in motion policy");
  property p_img_sub;
    image_trigger_out |-> trigger_out;
  endproperty
  a_img_sub: assert property (p_img_sub) else $error("image trigger without trigger");
  property p_img_gate;
    !image_enable_out [*3] |-> !$rose(image_trigger_out);
  endproperty
  a_img_gate: assert property (p_img_gate) else $error("image trigger while masked");
  property p_width;
    $fell(trigger_out) |-> run_reg >= 8'(strb_reg);
  endproperty
  a_width: assert property (p_width) else $error("trigger pulse too short");
  property p_no_src;
    $rose(trigger_out) |-> src_reg;
  endproperty
  a_no_src: assert property (p_no_src) else $error("trigger with both phases off");
  // latency from a line edge to its trigger is well under twelve cycles
  property p_quiet;
    (meth_reg || div_reg[15:0] == 16'h0) && quiet_reg > 5'h0C |-> !$rose(trigger_out);
  endproperty
  a_quiet: assert property (p_quiet) else $error("trigger without encoder edge");
  c_trig: cover property ($rose(trigger_out));
  c_mask: cover property ($fell(image_enable_out));
  c_wide: cover property ($fell(trigger_out) && run_reg > 8'h02);
endmodule

bind ret_line_trigger ret_line_trigger_monitor u_mon (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .line_in, .trigger_out, .image_trigger_out, .image_enable_out);

// ===== tb/ret_line_trigger_tb.sv
`timescale 1ns/1ps
`include "ret_consts.svh"
module ret_line_trigger_tb;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [2:0]  line_in;
  logic        trigger_out;
  logic        image_trigger_out;
  logic        image_enable_out;
  logic        step = 1'b0;
  logic        fwd = 1'b0;
  logic        trg_prev = 1'b0;
  logic        img_prev = 1'b0;
  logic [31:0] trg_cnt = 32'h0;
  logic [31:0] img_cnt = 32'h0;
  logic [31:0] hi_cnt = 32'h0;
  logic [31:0] t0;
  logic [31:0] i0;
  logic [31:0] h0;
  int          miscompares = 0;
  int          check_count = 0;
  ////////////////////////////////////////
  always #50 clk = !clk;

  ret_line_trigger uut (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .line_in,
    .trigger_out, .image_trigger_out, .image_enable_out);
  ret_encoder_model enc (.clk, .step, .fwd, .line_out(line_in));

  always @(posedge clk)
  begin
    trg_prev <= trigger_out;
    img_prev <= image_trigger_out;
    trg_cnt  <= trg_cnt + 32'(trigger_out && !trg_prev);
    img_cnt  <= img_cnt + 32'(image_trigger_out && !img_prev);
    hi_cnt   <= hi_cnt + 32'(trigger_out);
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe, so it is taken mid-cycle
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask

  // spacing leaves room for the slowest filter and the widest strobe used here
  task automatic steps(input int n, input logic f);
    repeat (n)
    begin
      @(posedge clk);
      step <= 1'b1;
      fwd  <= f;
      @(posedge clk);
      step <= 1'b0;
      repeat (12) @(posedge clk);
    end
  endtask

  task automatic mark;
    t0 = trg_cnt;
    i0 = img_cnt;
    h0 = hi_cnt;
  endtask

  task automatic cnt_chk(input logic [31:0] te, input logic [31:0] ie);
    chk(trg_cnt - t0, te);
    chk(img_cnt - i0, ie);
  endtask

  task automatic summarize;
    $display("compares %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (100000) @(posedge clk);
    miscompares++;
    summarize();
  end

  initial
  begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(`RET_OFS_CTRL, 32'h0000_0050);
    rd_chk(`RET_OFS_SRC, 32'h0);
    rd_chk(`RET_OFS_DIV, 32'h0001_0000);
    rd_chk(`RET_OFS_SKIP, 32'h0);
    rd_chk(`RET_OFS_FILT, 32'h0);
    rd_chk(`RET_OFS_STRB, 32'h0000_0064);
    rd_chk(`RET_OFS_MAXI, 32'h0);
    rd_chk(`RET_OFS_BACKLOG, 32'h0);
    rd_chk(8'h40, 32'h0);
    mark();
    steps(4, 1'b1);
    cnt_chk(32'h0, 32'h0);
    wr(`RET_OFS_SRC, 32'h0000_1817);
    wr(`RET_OFS_STRB, 32'h0000_012C);
    wr(`RET_OFS_CTRL, 32'h0000_0051);
    wr(`RET_OFS_SKIP, 32'h2);
    mark();
    steps(7, 1'b1);
    cnt_chk(32'h2, 32'h2);
    chk(hi_cnt - h0, 32'h6);
    wr(`RET_OFS_CTRL, 32'h0000_0050);
    wr(`RET_OFS_DIV, 32'h0002_0000);
    wr(`RET_OFS_FILT, 32'h0000_0096);
    mark();
    steps(6, 1'b0);
    cnt_chk(32'h3, 32'h3);
    wr(`RET_OFS_DIV, 32'h0001_0000);
    wr(`RET_OFS_CTRL, 32'h0001_0010);
    mark();
    steps(3, 1'b1);
    cnt_chk(32'h3, 32'h3);
    steps(2, 1'b0);
    rd_chk(`RET_OFS_BACKLOG, 32'h2);
    chk(32'(image_enable_out), 32'h0);
    mark();
    steps(1, 1'b1);
    cnt_chk(32'h1, 32'h0);
    rd_chk(`RET_OFS_BACKLOG, 32'h1);
    steps(1, 1'b1);
    rd_chk(`RET_OFS_BACKLOG, 32'h0);
    chk(32'(image_enable_out), 32'h1);
    mark();
    steps(1, 1'b1);
    cnt_chk(32'h1, 32'h1);
    wr(`RET_OFS_CTRL, 32'h0001_0020);
    steps(2, 1'b1);
    rd_chk(`RET_OFS_BACKLOG, 32'h2);
    steps(2, 1'b0);
    mark();
    steps(1, 1'b0);
    cnt_chk(32'h1, 32'h1);
    wr(`RET_OFS_CTRL, 32'h0000_0550);
    wr(`RET_OFS_MAXI, 32'h0000_003C);
    rd_chk(`RET_OFS_CTRL, 32'h0000_0550);
    rd_chk(`RET_OFS_MAXI, 32'h0000_003C);
    mark();
    steps(2, 1'b1);
    cnt_chk(32'h2, 32'h2);
    // half-step divisor: two paced triggers per 14-clock input period once settled
    wr(`RET_OFS_CTRL, 32'h0000_0150);
    wr(`RET_OFS_DIV, 32'h0000_8000);
    steps(4, 1'b1);
    mark();
    steps(2, 1'b1);
    cnt_chk(32'h4, 32'h4);
    chk(hi_cnt - h0, 32'h0000_000C);
    wr(`RET_OFS_DIV, 32'h0001_0000);
    summarize();
  end
endmodule
